/* cbl_loader.v */
`timescale 1ns/1ns
`default_nettype none
`include "cbl_regs.vh"
// ************
// configuration bitstream loader
// ************
module cbl_loader #(
  parameter [31:0] WAKE_CYC = `CBL_WAKE_CYC,
  parameter [31:0] IMAGE_BITS = 32'h00000400
) (
  input wire core_clk,
  input wire nrst,
  input wire [1:0] mode_sel,
  input wire config_reset_low,
  input wire flash_miso,
  input wire pas_ss_n,
  input wire pas_sck,
  input wire pas_mosi,
  input wire tck,
  input wire tms,
  input wire tdi,
  output reg flash_sck,
  output reg flash_cs_n,
  output reg flash_mosi,
  output reg flash_oe,
  output reg tdo,
  output reg cfg_we,
  output reg [31:0] cfg_addr,
  output reg cfg_bit,
  output reg cfg_done,
  output reg user_mode
);
  // ************
  // synchronised pins
  // ************
  wire rst_s, miso_s, pss_s, psck_s, pmosi_s, tck_s, tms_s, tdi_s;
  cbl_sync u_s0 (.core_clk(core_clk), .nrst(nrst), .din(config_reset_low), .dout(rst_s));
  cbl_sync u_s1 (.core_clk(core_clk), .nrst(nrst), .din(flash_miso), .dout(miso_s));
  cbl_sync u_s2 (.core_clk(core_clk), .nrst(nrst), .din(pas_ss_n), .dout(pss_s));
  cbl_sync u_s3 (.core_clk(core_clk), .nrst(nrst), .din(pas_sck), .dout(psck_s));
  cbl_sync u_s4 (.core_clk(core_clk), .nrst(nrst), .din(pas_mosi), .dout(pmosi_s));
  cbl_sync u_s5 (.core_clk(core_clk), .nrst(nrst), .din(tck), .dout(tck_s));
  cbl_sync u_s6 (.core_clk(core_clk), .nrst(nrst), .din(tms), .dout(tms_s));
  cbl_sync u_s7 (.core_clk(core_clk), .nrst(nrst), .din(tdi), .dout(tdi_s));
  // strap pins settle long before the load edge, but are synced like any pin
  wire [1:0] mode_s;
  cbl_sync u_s8 (.core_clk(core_clk), .nrst(nrst), .din(mode_sel[0]), .dout(mode_s[0]));
  cbl_sync u_s9 (.core_clk(core_clk), .nrst(nrst), .din(mode_sel[1]), .dout(mode_s[1]));
  // ************
  // states
  // ************
  localparam [2:0] ST_HOLD = 3'h0; // waiting for reset release
  localparam [2:0] ST_WAKE = 3'h1; // shifting wake command
  localparam [2:0] ST_WAIT = 3'h2; // post-wake delay
  localparam [2:0] ST_READ = 3'h3; // command, address, dummy
  localparam [2:0] ST_DATA = 3'h4; // bitstream in
  localparam [2:0] ST_SLV = 3'h5; // passive or jtag load
  localparam [2:0] ST_DONE = 3'h6; // user operation
  // outgoing words, first bit on top; dummy byte trails the address
  localparam [39:0] WAKE_WORD = {`CBL_CMD_WAKE, 32'h00000000};
  localparam [39:0] READ_WORD = {`CBL_CMD_FREAD, `CBL_START_ADDR, 8'h00};
  reg [2:0] st_r;
  reg rst_d_r; // previous reset level, for edge find
  reg psck_d_r; // previous passive clock
  reg tck_d_r; // previous jtag clock
  reg [1:0] mode_r; // mode captured at load start
  reg [3:0] div_r; // oscillator half-period divider
  reg [5:0] bit_r; // header bit index
  reg [39:0] sh_r; // header shift register
  reg [31:0] wait_r; // wake delay counter
  wire tick = (div_r == `CBL_SCK_HALF - 4'h1);
  wire fall_tick = tick & flash_sck; // drive edge
  wire rise_tick = tick & ~flash_sck; // sample edge
  wire start = rst_s & ~rst_d_r; // released reset pin
  wire p_rise = psck_s & ~psck_d_r & ~pss_s;
  wire t_rise = tck_s & ~tck_d_r & ~tms_s;
  // next memory bit counter, shared by all modes
  function [31:0] inc32;
    input [31:0] v;
    begin
      inc32 = v + 32'h00000001;
    end
  endfunction
  // ************
  // main sequencer
  // ************
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_HOLD;
      rst_d_r <= 1'b0;
      psck_d_r <= 1'b0;
      tck_d_r <= 1'b0;
      mode_r <= `CBL_MODE_ACTIVE;
      div_r <= 4'h0;
      bit_r <= 6'h00;
      sh_r <= 40'h0000000000;
      wait_r <= 32'h00000000;
      flash_sck <= 1'b0;
      flash_cs_n <= 1'b1;
      flash_mosi <= 1'b0;
      flash_oe <= 1'b0;
      tdo <= 1'b0;
      cfg_we <= 1'b0;
      cfg_addr <= 32'h00000000;
      cfg_bit <= 1'b0;
      cfg_done <= 1'b0;
      user_mode <= 1'b0;
    end else begin
      rst_d_r <= rst_s;
      psck_d_r <= psck_s;
      tck_d_r <= tck_s;
      cfg_we <= 1'b0;
      // free-running internal oscillator, only shown on pin in active load
      div_r <= tick ? 4'h0 : div_r + 4'h1;
      if (!rst_s) begin
        // pin low aborts the load and clears done and user mode
        st_r <= ST_HOLD;
        flash_cs_n <= 1'b1;
        flash_oe <= 1'b0;
        flash_sck <= 1'b0;
        cfg_done <= 1'b0;
        user_mode <= 1'b0;
      end else begin
        case (st_r)
          ST_HOLD: begin
            if (start) begin
              mode_r <= mode_s;
              cfg_addr <= 32'h00000000;
              if (mode_s == `CBL_MODE_ACTIVE) begin
                st_r <= ST_WAKE;
                // first bit set up ahead of the first clock rise, not on it
                flash_mosi <= WAKE_WORD[39];
                sh_r <= {WAKE_WORD[38:0], 1'b0};
                bit_r <= 6'h00;
                flash_oe <= 1'b1;
                flash_cs_n <= 1'b0;
              end else if (mode_s == `CBL_MODE_PASSIVE || mode_s == `CBL_MODE_JTAG) begin
                st_r <= ST_SLV;
              end
            end
          end
          ST_WAKE: begin
            if (tick) begin
              flash_sck <= ~flash_sck;
            end
            // next bit leaves on the falling clock, so it is stable at the rise
            if (fall_tick) begin
              flash_mosi <= sh_r[39];
              sh_r <= {sh_r[38:0], 1'b0};
              bit_r <= bit_r + 6'h01;
              if (bit_r == 6'h07) begin
                flash_cs_n <= 1'b1;
                wait_r <= 32'h00000000;
                st_r <= ST_WAIT;
              end
            end
          end
          ST_WAIT: begin
            wait_r <= inc32(wait_r);
            if (wait_r >= WAKE_CYC - 32'h00000001) begin
              st_r <= ST_READ;
              flash_mosi <= READ_WORD[39];
              sh_r <= {READ_WORD[38:0], 1'b0};
              bit_r <= 6'h00;
              flash_cs_n <= 1'b0;
            end
          end
          ST_READ: begin
            if (tick) begin
              flash_sck <= ~flash_sck;
            end
            // header shifts the same way as the wake word
            if (fall_tick) begin
              flash_mosi <= sh_r[39];
              sh_r <= {sh_r[38:0], 1'b0};
              bit_r <= bit_r + 6'h01;
              if (bit_r == 6'h27) begin
                st_r <= ST_DATA;
              end
            end
          end
          ST_DATA: begin
            if (tick) begin
              flash_sck <= ~flash_sck;
            end
            if (rise_tick) begin
              // flash answers the read with the image
              cfg_bit <= miso_s;
              cfg_we <= 1'b1;
              cfg_addr <= inc32(cfg_addr);
              if (inc32(cfg_addr) == IMAGE_BITS) begin
                flash_cs_n <= 1'b1;
                flash_oe <= 1'b0;
                // clock parks low; the last bit is already read from the line
                flash_sck <= 1'b0;
                st_r <= ST_DONE;
              end
            end
          end
          ST_SLV: begin
            // external master paces passive load; test port paces jtag load
            if ((mode_r == `CBL_MODE_PASSIVE && p_rise) ||
                (mode_r == `CBL_MODE_JTAG && t_rise)) begin
              cfg_bit <= (mode_r == `CBL_MODE_JTAG) ? tdi_s : pmosi_s;
              tdo <= tdi_s;
              cfg_we <= 1'b1;
              cfg_addr <= inc32(cfg_addr);
              if (inc32(cfg_addr) == IMAGE_BITS) begin
                st_r <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            cfg_done <= 1'b1;
            user_mode <= 1'b1;
          end
          default: begin
            st_r <= ST_HOLD;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* cbl_regs.vh */
// Summary of operation
// - volatile memory loaded before user operation
// - control block writes memory from bitstream
// - three modes: active, passive, jtag
// - active mode drives oscillator clock to flash
// - wake flash with release-power-down first
// - wait at least 30 us before read
// - fast read from address zero
// - passive: external master drives clock, data
// - reset low then rising edge starts load
// - jtag mode loads through test port
`ifndef CBL_REGS_VH
`define CBL_REGS_VH
// ************
// mode codes
// ************
`define CBL_MODE_ACTIVE 2'h0
`define CBL_MODE_PASSIVE 2'h1
`define CBL_MODE_JTAG 2'h2
// ************
// flash commands
// ************
`define CBL_CMD_WAKE 8'hAB
`define CBL_CMD_FREAD 8'h0B
`define CBL_START_ADDR 24'h000000
`define CBL_DUMMY_BITS 8
// ************
// timing
// ************
`define CBL_CLK_MHZ 250
`define CBL_WAKE_US 30
`define CBL_WAKE_CYC (`CBL_WAKE_US * `CBL_CLK_MHZ)
`define CBL_SCK_HALF 4'h4
`endif

/* cbl_sync.v */
`timescale 1ns/1ns
`default_nettype none
// ************
// two-stage synchroniser for pin inputs
// ************
module cbl_sync (
  input wire core_clk,
  input wire nrst,
  input wire din,
  output reg dout
);
  reg meta_r; // first stage, read only by dout
  // metastability guard
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 1'b0;
      dout <= 1'b0;
    end else begin
      meta_r <= din;
      dout <= meta_r;
    end
  end
endmodule
`default_nettype wire

/* cbl_sva.sv */
`timescale 1ns/1ns
`default_nettype none
// ****
// loader port checker
// ****
module cbl_sva #(
  parameter WAKE_CYC = 20,
  parameter [31:0] IMAGE_BITS = 32'h10
) (
  input wire core_clk,
  input wire nrst,
  input wire config_reset_low,
  input wire flash_cs_n,
  input wire flash_oe,
  input wire cfg_we,
  input wire [31:0] cfg_addr,
  input wire cfg_done,
  input wire user_mode
);
  // cycles the chip select has stayed high
  // starts saturated, so the first frame after reset owes no gap
  reg [15:0] hi_cnt_r;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) hi_cnt_r <= 16'hFFFF;
    else if (!flash_cs_n) hi_cnt_r <= 16'h0;
    else if (hi_cnt_r != 16'hFFFF) hi_cnt_r <= hi_cnt_r + 16'h1;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence cs_fall_s; $fell(flash_cs_n); endsequence
  sequence cs_end_s; $rose(flash_cs_n) ##0 (cfg_addr != 32'h0); endsequence
  wake_gap_a: assert property (cs_fall_s |-> hi_cnt_r >= WAKE_CYC)
    else $error("select gap too short");
  cs_hold_a: assert property (cs_end_s |-> cfg_addr == IMAGE_BITS)
    else $error("select released early");
  done_count_a: assert property ($rose(cfg_done) |-> cfg_addr == IMAGE_BITS)
    else $error("done at wrong count");
  user_gate_a: assert property (user_mode |-> cfg_done)
    else $error("user mode before load");
  we_pulse_a: assert property (cfg_we |=> !cfg_we)
    else $error("write strobe too long");
  addr_step_a: assert property (cfg_we |-> cfg_addr == $past(cfg_addr) + 32'h1)
    else $error("address not stepped");
  oe_drive_a: assert property (!flash_cs_n |-> flash_oe)
    else $error("flash pins undriven");
  pin_abort_a: assert property (!config_reset_low [*6] |-> flash_cs_n && !cfg_we)
    else $error("active while pin low");
endmodule
`default_nettype wire

/* cbl_flash_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbl_regs.vh"
// ****
// serial flash model
// ****
module cbl_flash_model #(
  parameter [15:0] IMG = 16'hC5A3
) (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] op_prev,
  output logic [7:0] op_last,
  output logic [23:0] addr
);
  logic [31:0] sh = 32'h0; // incoming bits
  logic miso_r = 1'b0; // line level, single driver
  int n = 0; // bits since select
  assign miso = miso_r;
  // select restarts the count; command bits taken on rising clock
  always @(negedge cs_n or posedge sck) begin
    if (!cs_n && !sck) begin
      n = 0;
    end else if (!cs_n) begin
      sh = {sh[30:0], mosi};
      n = n + 1;
      if (n == 8) op_prev = op_last;
      if (n == 8) op_last = sh[7:0];
      if (n == 32) addr = sh[23:0];
    end
  end
  // image on falling clock after the header; released line shows the inverse
  always @(negedge sck or posedge cs_n) begin
    if (!cs_n && op_last == `CBL_CMD_FREAD && n >= 40 && n < 56) miso_r <= IMG[55 - n];
    else miso_r <= ~miso_r;
  end
endmodule
`default_nettype wire

/* cbl_loader_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cbl_regs.vh"
// ****
// loader bench
// ****
module cbl_loader_bench;
  localparam [15:0] IMG = 16'hC5A3;
  reg core_clk = 1'b0, nrst = 1'b0, config_reset_low = 1'b0;
  reg [1:0] mode_sel = 2'h0;
  reg pas_ss_n = 1'b1, pas_sck = 1'b0, pas_mosi = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
  wire flash_miso, flash_sck, flash_cs_n, flash_mosi, flash_oe, tdo, cfg_we, cfg_bit;
  wire cfg_done, user_mode;
  wire [31:0] cfg_addr;
  wire [7:0] op_prev, op_last;
  wire [23:0] faddr;
  int failures = 0, checked = 0;
  reg [15:0] got = 16'h0; // bits written, first one ends on top
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) if (cfg_we) got <= {got[14:0], cfg_bit};
  cbl_loader #(.WAKE_CYC(20), .IMAGE_BITS(32'h10)) dut (.core_clk(core_clk), .nrst(nrst),
    .mode_sel(mode_sel), .config_reset_low(config_reset_low), .flash_miso(flash_miso),
    .pas_ss_n(pas_ss_n), .pas_sck(pas_sck), .pas_mosi(pas_mosi), .tck(tck), .tms(tms),
    .tdi(tdi), .flash_sck(flash_sck), .flash_cs_n(flash_cs_n), .flash_mosi(flash_mosi),
    .flash_oe(flash_oe), .tdo(tdo), .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_bit(cfg_bit),
    .cfg_done(cfg_done), .user_mode(user_mode));
  cbl_flash_model #(.IMG(IMG)) u_flash (.sck(flash_sck), .cs_n(flash_cs_n), .mosi(flash_mosi),
    .miso(flash_miso), .op_prev(op_prev), .op_last(op_last), .addr(faddr));
  task end_of_test;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input [31:0] g, input [31:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  // fresh reset; pin held low past the wake gap, then raised
  task start(input [1:0] m);
    nrst <= 1'b0;
    config_reset_low <= 1'b0;
    repeat (8) @(posedge core_clk);
    nrst <= 1'b1;
    mode_sel <= m;
    repeat (30) @(posedge core_clk);
    config_reset_low <= 1'b1;
  endtask
  task wait_done;
    int i;
    for (i = 0; i < 8000 && cfg_done !== 1'b1; i++) @(posedge core_clk);
    if (cfg_done !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t load did not finish", $time);
      end_of_test;
    end
  endtask
  // external master: 6 core cycles per phase makes a 48 ns link clock
  task shift_in(input logic jt);
    int i;
    for (i = 15; i >= 0; i--) begin
      if (jt) tdi <= IMG[i]; else pas_mosi <= IMG[i];
      repeat (6) @(posedge core_clk);
      if (jt) tck <= 1'b1; else pas_sck <= 1'b1;
      repeat (6) @(posedge core_clk);
      if (jt) tck <= 1'b0; else pas_sck <= 1'b0;
    end
    wait_done;
  endtask
  task test_active;
    start(`CBL_MODE_ACTIVE);
    wait_done;
    chk(op_prev, `CBL_CMD_WAKE);
    chk(op_last, `CBL_CMD_FREAD);
    chk(faddr, `CBL_START_ADDR);
    chk(got, IMG);
    chk(cfg_addr, 32'h00000010);
    chk(flash_cs_n, 32'h1);
    chk(flash_sck, 32'h0);
    chk(user_mode, 32'h1);
    $display("active test done");
  endtask
  task test_passive;
    start(`CBL_MODE_PASSIVE);
    pas_ss_n <= 1'b0;
    shift_in(1'b0);
    chk(got, IMG);
    chk(flash_oe, 32'h0);
    chk(user_mode, 32'h1);
    pas_ss_n <= 1'b1;
    $display("passive test done");
  endtask
  task test_jtag;
    start(`CBL_MODE_JTAG);
    shift_in(1'b1);
    chk(got, IMG);
    chk(tdo, IMG[0]);
    chk(flash_cs_n, 32'h1);
    $display("jtag test done");
  endtask
  task test_unused;
    start(2'h3);
    repeat (300) @(posedge core_clk);
    chk(cfg_done, 32'h0);
    chk(flash_cs_n, 32'h1);
    chk(flash_oe, 32'h0);
    $display("unused mode test done");
  endtask
  initial begin
    @(posedge core_clk);
    test_active;
    test_passive;
    test_jtag;
    test_unused;
    end_of_test;
  end
endmodule
bind cbl_loader cbl_sva #(.WAKE_CYC(WAKE_CYC), .IMAGE_BITS(IMAGE_BITS)) u_sva (
  .core_clk(core_clk), .nrst(nrst), .config_reset_low(config_reset_low),
  .flash_cs_n(flash_cs_n), .flash_oe(flash_oe), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
  .cfg_done(cfg_done), .user_mode(user_mode));
`default_nettype wire
